// [hdl/sptr_pkg.sv]
package sptr_pkg;
    localparam int SPTR_NREG = 4;
    localparam logic [11:0] SPTR_OFF_CSR3 = 12'h080;
    localparam logic [11:0] SPTR_OFF_CSR4 = 12'h084;
    localparam logic [11:0] SPTR_OFF_CSR5 = 12'h088;
    localparam logic [11:0] SPTR_OFF_TL   = 12'h08c;
    localparam logic [3:0][11:0] SPTR_OFFS = {SPTR_OFF_TL, SPTR_OFF_CSR5,
                                              SPTR_OFF_CSR4, SPTR_OFF_CSR3};
    localparam logic [31:0] SPTR_RST_CSR3 = 32'h000f0000;
    localparam logic [31:0] SPTR_RST_CSR4 = 32'h00000000;
    localparam logic [31:0] SPTR_RST_CSR5 = 32'h33083333;
    localparam logic [31:0] SPTR_RST_TL   = 32'h00000094;
    localparam logic [3:0][31:0] SPTR_RSTS = {SPTR_RST_TL, SPTR_RST_CSR5,
                                              SPTR_RST_CSR4, SPTR_RST_CSR3};
    localparam logic [31:0] SPTR_WM_CSR3 = 32'hffffffff;
    localparam logic [31:0] SPTR_WM_CSR4 = 32'h00000000;
    localparam logic [31:0] SPTR_WM_CSR5 = 32'hc0000000;
    localparam logic [31:0] SPTR_WM_TL   = 32'h00000060;
    localparam logic [3:0][31:0] SPTR_WMS = {SPTR_WM_TL, SPTR_WM_CSR5,
                                             SPTR_WM_CSR4, SPTR_WM_CSR3};
    localparam int SPTR_IDX_CSR3 = 0;
    localparam int SPTR_IDX_CSR4 = 1;
    localparam int SPTR_IDX_CSR5 = 2;
    localparam int SPTR_IDX_TL   = 3;
    localparam int SPTR_B5_CFG_SEL   = 11;
    localparam int SPTR_B5_RATE_CTRL = 30;
    localparam int SPTR_B5_GEN1_ONLY = 31;
    localparam int SPTR_BT_PW_BYPASS = 5;
    localparam int SPTR_BT_ORDER_OFF = 6;
    localparam int SPTR_BT_CNT_LO    = 8;
    localparam int SPTR_BT_PORT_DIS  = 10;
    localparam logic [31:0] SPTR_UPSET_CSR5 = 32'h3fffffff;
    localparam logic [31:0] SPTR_UPSET_TL   = 32'h000000ff;
    localparam logic [1:0] SPTR_STRAP_CYC = 2'h3;
    typedef enum logic [1:0] {SPTR_ST_DEFAULT, SPTR_ST_LOAD, SPTR_ST_RUN} sptr_state_t;
endpackage

// [hdl/sptr_regs.sv]
module sptr_regs
    import sptr_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        upstream_strap,
    input  wire logic        up_link_down,
    input  wire logic [31:0] up_csr5_in,
    input  wire logic [31:0] up_tl_in,
    input  wire logic        ovr_en,
    input  wire logic        ovr_from_eeprom,
    input  wire logic [11:0] ovr_addr,
    input  wire logic [31:0] ovr_data,
    input  wire logic        ovr_done,
    input  wire logic        cfg_req,
    input  wire logic        cfg_wr,
    input  wire logic [11:0] cfg_addr,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic             cfg_ack,
    output logic [31:0]      cfg_rdata,
    output logic [31:0]      csr5_out,
    output logic [31:0]      tl_out,
    output logic             port_disable,
    output logic             relaxed_order_off,
    output logic             posted_write_bypass_off,
    output logic             rate_change_control,
    output logic [1:0]       rate_change_attempt_count,
    output logic             first_speed_only_flag,
    output logic             ready
);
    sptr_state_t state_ff;
    logic [1:0]  cnt_ff;
    logic        strap_s1_ff;
    logic        strap_s2_ff;
    logic        up_ff;
    logic        ack_ff;
    logic [31:0] rdata_ff;
    logic        cfg_take;
    logic        ovr_take;
    logic        def_load;
    logic        cfg_sel;
    logic [31:0] eff_csr5;
    logic [31:0] eff_tl;
    logic [31:0] rd_val;
    logic [3:0][31:0] q;

    sptr_wr_if w [SPTR_NREG] ();

    genvar gi;
    generate
        for (gi = 0; gi < SPTR_NREG; gi++) begin : g_word
            sptr_word #(
                .RST   (SPTR_RSTS[gi]),
                .WMASK (SPTR_WMS[gi])
            ) u_word (
                .clk_sys (clk_sys),
                .rst_b   (rst_b),
                .port    (w[gi])
            );
            assign w[gi].ld_en   = def_load || (ovr_take && ovr_addr == SPTR_OFFS[gi]);
            // Ordering bit masked off non-EEPROM override loads.
            assign w[gi].ld_mask = (!def_load && gi == SPTR_IDX_TL && !ovr_from_eeprom)
                                   ? ~(32'h1 << SPTR_BT_ORDER_OFF) : 32'hffffffff;
            assign w[gi].ld_data = !def_load ? ovr_data :
                                   (gi == SPTR_IDX_CSR5)
                                   ? {SPTR_RSTS[gi][31], strap_s2_ff, SPTR_RSTS[gi][29:0]}
                                   : SPTR_RSTS[gi];
            assign w[gi].sw_en   = cfg_take && cfg_wr && cfg_addr == SPTR_OFFS[gi];
            assign w[gi].sw_be   = cfg_be;
            assign w[gi].sw_data = cfg_wdata;
            assign q[gi]         = w[gi].q;
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            strap_s1_ff <= 1'b0;
            strap_s2_ff <= 1'b0;
        end else begin
            strap_s1_ff <= upstream_strap;
            strap_s2_ff <= strap_s1_ff;
        end
    end

    // Upstream-set fields taken from upstream instance.
    always_comb begin
        eff_csr5 = up_ff ? q[SPTR_IDX_CSR5]
                         : (q[SPTR_IDX_CSR5] & ~SPTR_UPSET_CSR5) | (up_csr5_in & SPTR_UPSET_CSR5);
        eff_tl   = up_ff ? q[SPTR_IDX_TL]
                         : (q[SPTR_IDX_TL] & ~SPTR_UPSET_TL) | (up_tl_in & SPTR_UPSET_TL);
    end

    assign cfg_sel  = eff_csr5[SPTR_B5_CFG_SEL];
    assign def_load = (state_ff == SPTR_ST_DEFAULT) && (cnt_ff == SPTR_STRAP_CYC - 2'h1);
    // Overrides only in the load phase.
    assign ovr_take = ovr_en && (state_ff == SPTR_ST_LOAD);
    assign cfg_take = cfg_req && !ack_ff && (state_ff == SPTR_ST_RUN);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= SPTR_ST_DEFAULT;
            cnt_ff   <= 2'h0;
            up_ff    <= 1'b0;
        end else begin
            case (state_ff)
                SPTR_ST_DEFAULT: begin
                    if (def_load) begin
                        up_ff    <= strap_s2_ff;
                        cnt_ff   <= 2'h0;
                        state_ff <= SPTR_ST_LOAD;
                    end else begin
                        cnt_ff <= cnt_ff + 2'h1;
                    end
                end
                SPTR_ST_LOAD: begin
                    if (ovr_done) begin
                        state_ff <= SPTR_ST_RUN;
                    end
                end
                SPTR_ST_RUN: begin
                    if (up_link_down && !cfg_sel) begin
                        state_ff <= SPTR_ST_DEFAULT;
                    end
                end
                default: begin
                    state_ff <= SPTR_ST_DEFAULT;
                end
            endcase
        end
    end

    always_comb begin
        rd_val = 32'h0;
        if (cfg_addr == SPTR_OFF_CSR3) begin
            rd_val = q[SPTR_IDX_CSR3];
        end else if (cfg_addr == SPTR_OFF_CSR4) begin
            // Only the upstream instance carries this word.
            rd_val = up_ff ? q[SPTR_IDX_CSR4] : 32'h0;
        end else if (cfg_addr == SPTR_OFF_CSR5) begin
            rd_val = eff_csr5;
        end else if (cfg_addr == SPTR_OFF_TL) begin
            rd_val = eff_tl;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h0;
        end else begin
            ack_ff <= cfg_take;
            if (cfg_take) begin
                rdata_ff <= cfg_wr ? 32'h0 : rd_val;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            port_disable              <= 1'b0;
            relaxed_order_off         <= 1'b0;
            posted_write_bypass_off   <= 1'b0;
            rate_change_control       <= 1'b0;
            rate_change_attempt_count <= 2'h0;
            first_speed_only_flag     <= 1'b0;
            ready                     <= 1'b0;
        end else begin
            port_disable              <= eff_tl[SPTR_BT_PORT_DIS];
            relaxed_order_off         <= eff_tl[SPTR_BT_ORDER_OFF];
            posted_write_bypass_off   <= eff_tl[SPTR_BT_PW_BYPASS];
            rate_change_control       <= eff_csr5[SPTR_B5_RATE_CTRL];
            rate_change_attempt_count <= eff_tl[SPTR_BT_CNT_LO+:2];
            first_speed_only_flag     <= eff_csr5[SPTR_B5_GEN1_ONLY];
            ready                     <= (state_ff == SPTR_ST_RUN);
        end
    end

    assign cfg_ack   = ack_ff;
    assign cfg_rdata = rdata_ff;
    assign csr5_out  = q[SPTR_IDX_CSR5];
    assign tl_out    = q[SPTR_IDX_TL];

    a_linkdown_reset: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state_ff == SPTR_ST_RUN && up_link_down && !cfg_sel |=> state_ff == SPTR_ST_DEFAULT)
        else $error("link-down did not reset configuration");
    a_linkdown_keep: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state_ff == SPTR_ST_RUN && up_link_down && cfg_sel && !cfg_take
        |=> state_ff == SPTR_ST_RUN && $stable(q[SPTR_IDX_CSR3]))
        else $error("configuration lost on link-down");
    a_rate_default: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(state_ff == SPTR_ST_LOAD) |-> q[SPTR_IDX_CSR5][SPTR_B5_RATE_CTRL] == up_ff)
        else $error("rate change control default wrong");
    a_count_default: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(state_ff == SPTR_ST_LOAD) |-> q[SPTR_IDX_TL][SPTR_BT_CNT_LO+:2] == 2'h0)
        else $error("attempt count default not zero");
    a_order_out: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cfg_take && cfg_wr && cfg_addr == SPTR_OFF_TL && cfg_be[0] && up_ff
        |-> ##2 relaxed_order_off == $past(cfg_wdata[SPTR_BT_ORDER_OFF], 2))
        else $error("ordering override not applied");
    a_order_smbus: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ovr_take && !ovr_from_eeprom && ovr_addr == SPTR_OFF_TL
        |=> $stable(q[SPTR_IDX_TL][SPTR_BT_ORDER_OFF]))
        else $error("serial path changed ordering bit");
    a_port_disable: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ##1 port_disable == $past(eff_tl[SPTR_BT_PORT_DIS]))
        else $error("port disable not following field");
    a_ovr_load: assert property (@(posedge clk_sys) disable iff (!rst_b)
        ovr_take && ovr_addr == SPTR_OFF_CSR3 |=> q[SPTR_IDX_CSR3] == $past(ovr_data))
        else $error("override did not load");
    a_up_copy: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cfg_take && !cfg_wr && !up_ff && cfg_addr == SPTR_OFF_CSR5
        |=> cfg_rdata[29:0] == $past(up_csr5_in[29:0]))
        else $error("downstream read its own upstream-set copy");
    a_run_no_ovr: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state_ff == SPTR_ST_RUN && ovr_en && !cfg_take |=> $stable(q[SPTR_IDX_CSR3]))
        else $error("override accepted outside load phase");

    c_linkdown: cover property (@(posedge clk_sys) disable iff (!rst_b)
        state_ff == SPTR_ST_RUN && up_link_down);
    c_eeprom_tl: cover property (@(posedge clk_sys) disable iff (!rst_b)
        ovr_take && ovr_from_eeprom && ovr_addr == SPTR_OFF_TL);
    c_cfg_write: cover property (@(posedge clk_sys) disable iff (!rst_b)
        cfg_take && cfg_wr ##1 cfg_ack);
    c_down_read: cover property (@(posedge clk_sys) disable iff (!rst_b)
        cfg_take && !cfg_wr && !up_ff);
endmodule

// [hdl/sptr_word.sv]
module sptr_word #(
    parameter logic [31:0] RST   = 32'h00000000,
    parameter logic [31:0] WMASK = 32'h00000000
) (
    input  wire logic clk_sys,
    input  wire logic rst_b,
    sptr_wr_if.word   port
);
    logic [31:0] q_ff;
    logic [31:0] sw_mask;

    always_comb begin
        sw_mask = {{8{port.sw_be[3]}}, {8{port.sw_be[2]}},
                   {8{port.sw_be[1]}}, {8{port.sw_be[0]}}} & WMASK;
    end

    // Loads from the default or override path take priority over software writes.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            q_ff <= RST;
        end else if (port.ld_en) begin
            q_ff <= (q_ff & ~port.ld_mask) | (port.ld_data & port.ld_mask);
        end else if (port.sw_en) begin
            q_ff <= (q_ff & ~sw_mask) | (port.sw_data & sw_mask);
        end
    end

    assign port.q = q_ff;
endmodule

// [hdl/sptr_wr_if.sv]
interface sptr_wr_if;
    logic        ld_en;
    logic [31:0] ld_mask;
    logic [31:0] ld_data;
    logic        sw_en;
    logic [3:0]  sw_be;
    logic [31:0] sw_data;
    logic [31:0] q;
    modport ctl  (output ld_en, ld_mask, ld_data, sw_en, sw_be, sw_data, input q);
    modport word (input ld_en, ld_mask, ld_data, sw_en, sw_be, sw_data, output q);
endinterface

// [testbench/tb_top.sv]
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_sys, rst_b, upstream_strap, up_link_down, ovr_en, ovr_from_eeprom;
    logic        ovr_done, cfg_req, cfg_wr, cfg_ack, ready, port_disable, relaxed_order_off;
    logic        posted_write_bypass_off, rate_change_control, first_speed_only_flag;
    logic [1:0]  rate_change_attempt_count;
    logic [3:0]  cfg_be;
    logic [11:0] ovr_addr, cfg_addr;
    logic [31:0] up_csr5_in, up_tl_in, ovr_data, cfg_wdata, cfg_rdata, csr5_out, tl_out, rd;
    int          n_errors, checks;

    sptr_regs i_dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .upstream_strap(upstream_strap),
        .up_link_down(up_link_down), .up_csr5_in(up_csr5_in), .up_tl_in(up_tl_in),
        .ovr_en(ovr_en), .ovr_from_eeprom(ovr_from_eeprom), .ovr_addr(ovr_addr),
        .ovr_data(ovr_data), .ovr_done(ovr_done), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
        .cfg_rdata(cfg_rdata), .csr5_out(csr5_out), .tl_out(tl_out),
        .port_disable(port_disable), .relaxed_order_off(relaxed_order_off),
        .posted_write_bypass_off(posted_write_bypass_off),
        .rate_change_control(rate_change_control),
        .rate_change_attempt_count(rate_change_attempt_count),
        .first_speed_only_flag(first_speed_only_flag), .ready(ready)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // The request is held until the edge that samples the acknowledge high.
    task automatic cfg(input logic wr, input logic [11:0] a, input logic [3:0] be,
                       input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        cfg_req <= 1'b1;
        cfg_wr <= wr;
        cfg_addr <= a;
        cfg_be <= be;
        cfg_wdata <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (cfg_ack === 1'b1) break;
        end
        if (i == 20) chk("cfg_ack", 32'h1, 32'h0);
        rd = cfg_rdata;
        cfg_req <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        cfg(1'b0, a, 4'h0, 32'h0);
        chk($sformatf("reg %h", a), exp, rd);
    endtask

    task automatic ovr(input logic ee, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        ovr_en <= 1'b1;
        ovr_from_eeprom <= ee;
        ovr_addr <= a;
        ovr_data <= d;
        @(posedge clk_sys);
        ovr_en <= 1'b0;
    endtask

    task automatic boot(input logic s);
        @(posedge clk_sys);
        rst_b <= 1'b0;
        upstream_strap <= s;
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (5) @(posedge clk_sys);
    endtask

    task automatic wait_rdy(input logic v);
        int i;
        for (i = 0; i < 40; i++) begin
            @(posedge clk_sys);
            if (ready === v) break;
        end
        chk("ready", {31'h0, v}, {31'h0, ready});
    endtask

    task automatic run();
        @(posedge clk_sys);
        ovr_done <= 1'b1;
        wait_rdy(1'b1);
        ovr_done <= 1'b0;
    endtask

    task automatic ldown();
        @(posedge clk_sys);
        up_link_down <= 1'b1;
        @(posedge clk_sys);
        up_link_down <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask

    task automatic t_defaults();
        boot(1'b1);
        run();
        rdchk(12'h080, 32'h000f0000);
        rdchk(12'h084, 32'h00000000);
        rdchk(12'h088, 32'h73083333);
        rdchk(12'h08c, 32'h00000094);
        rdchk(12'h090, 32'h00000000);
        chk("rate_ctl", 32'h1, {31'h0, rate_change_control});
        chk("attempts", 32'h0, {30'h0, rate_change_attempt_count});
        chk("order_off", 32'h0, {31'h0, relaxed_order_off});
    endtask

    task automatic t_sw_access();
        cfg(1'b1, 12'h080, 4'h5, 32'hffffffff);
        chk("wr_rdata", 32'h0, rd);
        rdchk(12'h080, 32'h00ff00ff);
        cfg(1'b1, 12'h084, 4'hf, 32'hffffffff);
        rdchk(12'h084, 32'h00000000);
        cfg(1'b1, 12'h088, 4'hf, 32'h00000000);
        rdchk(12'h088, 32'h33083333);
        chk("rate_ctl", 32'h0, {31'h0, rate_change_control});
        cfg(1'b1, 12'h08c, 4'hf, 32'hffffffff);
        rdchk(12'h08c, 32'h000000f4);
        chk("order_off", 32'h1, {31'h0, relaxed_order_off});
        chk("bypass_off", 32'h1, {31'h0, posted_write_bypass_off});
        cfg(1'b1, 12'h090, 4'hf, 32'hffffffff);
        rdchk(12'h090, 32'h00000000);
    endtask

    // A serial-path load must not move the ordering bit set by the EEPROM.
    task automatic t_override();
        boot(1'b1);
        ovr(1'b1, 12'h08c, 32'h00000040);
        ovr(1'b0, 12'h08c, 32'h00000700);
        ovr(1'b0, 12'h080, 32'h12345678);
        ovr(1'b1, 12'h088, 32'hb3083b33);
        run();
        rdchk(12'h08c, 32'h00000740);
        chk("order_off", 32'h1, {31'h0, relaxed_order_off});
        chk("port_dis", 32'h1, {31'h0, port_disable});
        chk("attempts", 32'h3, {30'h0, rate_change_attempt_count});
        ovr(1'b1, 12'h080, 32'h0badf00d);
        rdchk(12'h080, 32'h12345678);
        rdchk(12'h088, 32'hb3083b33);
        chk("gen1_only", 32'h1, {31'h0, first_speed_only_flag});
        cfg(1'b1, 12'h080, 4'hf, 32'hcafef00d);
        ldown();
        chk("ready", 32'h1, {31'h0, ready});
        rdchk(12'h080, 32'hcafef00d);
    endtask

    task automatic t_link_reset();
        boot(1'b1);
        run();
        cfg(1'b1, 12'h080, 4'hf, 32'hdeadbeef);
        cfg(1'b1, 12'h088, 4'h8, 32'h80000000);
        cfg(1'b1, 12'h08c, 4'h1, 32'h00000060);
        ldown();
        wait_rdy(1'b0);
        ovr(1'b0, 12'h084, 32'h11112222);
        run();
        rdchk(12'h080, 32'h000f0000);
        rdchk(12'h088, 32'h73083333);
        rdchk(12'h08c, 32'h00000094);
        rdchk(12'h084, 32'h11112222);
    endtask

    // Upper inputs carry bits that a downstream copy must not take over.
    task automatic t_downstream();
        up_csr5_in <= 32'hc0001800;
        up_tl_in <= 32'hffffff60;
        boot(1'b0);
        run();
        rdchk(12'h088, 32'h00001800);
        rdchk(12'h08c, 32'h00000060);
        rdchk(12'h084, 32'h00000000);
        chk("csr5_out", 32'h33083333, csr5_out);
        chk("tl_out", 32'h00000094, tl_out);
        chk("rate_ctl", 32'h0, {31'h0, rate_change_control});
        chk("bypass_off", 32'h1, {31'h0, posted_write_bypass_off});
        chk("order_off", 32'h1, {31'h0, relaxed_order_off});
        ldown();
        chk("ready", 32'h1, {31'h0, ready});
    endtask

    task automatic results();
        if (n_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        n_errors++;
        results();
    end

    initial begin
        {rst_b, up_link_down, ovr_en, ovr_from_eeprom, ovr_done, cfg_req, cfg_wr} = '0;
        upstream_strap = 1'b1;
        {cfg_be, ovr_addr, cfg_addr, up_csr5_in, up_tl_in, ovr_data, cfg_wdata} = '0;
        t_defaults();
        t_sw_access();
        t_override();
        t_link_reset();
        t_downstream();
        results();
    end
endmodule
